// >>> pkg/lslc_pkg.sv
`default_nettype none
package lslc_pkg;
  // Parallel word and line frame geometry.
  localparam int WORD_W = 10;
  localparam int FRAME_W = WORD_W + 2;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] FRAME_LAST = 4'hB;
  localparam logic [CNT_W-1:0] RCLK_HALF = 4'h6;
  localparam logic [CNT_W-1:0] RCLK_DONE = 4'hC;
  localparam logic [FRAME_W-1:0] ALIGN_PATTERN = 12'hFC0;
  localparam logic [FRAME_W-1:0] IDLE_FRAME = 12'h000;
  // Alignment request must be seen on this many selected clock edges.
  localparam logic [2:0] ALIGN_MIN_EDGES = 3'h5;
  // Word and reference clock limits the system must keep.
  localparam int LINK_CLK_MIN_MHZ = 20;
  localparam int LINK_CLK_MAX_MHZ = 66;
  localparam int SYS_CLK_MHZ = 40;
  localparam int LOCK_FRAMES_DEF = 4;
  localparam int REF_TIMEOUT_DEF = 64;
  // Register map, byte addresses.
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h0C;
  localparam int CTRL_TX_EN_BIT = 0;
  localparam int CTRL_RELOCK_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int EVT_W = 4;
  localparam int EVT_LOCK_GAINED = 0;
  localparam int EVT_LOCK_LOST = 1;
  localparam int EVT_ALIGN = 2;
  localparam int EVT_DROP = 3;
  localparam logic [EVT_W-1:0] MASK_RESET = 4'h0;
  localparam int STATE_LOCKED_BIT = 0;
  localparam int STATE_ALIGN_BIT = 1;
  localparam int STATE_WORD_LSB = 2;
  localparam int STATE_W = STATE_WORD_LSB + WORD_W;
  typedef enum logic [1:0] {
    RX_SLEEP,
    RX_HUNT,
    RX_TRAIN,
    RX_LOCKED
  } lslc_rx_state_e;
endpackage
`default_nettype wire

// >>> pkg/lslc_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lslc_reg_if;
  import lslc_pkg::*;
  logic tx_enable;
  logic relock;
  logic [EVT_W-1:0] events;
  logic [STATE_W-1:0] state;
  modport regs (output tx_enable, output relock, input events, input state);
  modport core (input tx_enable, input relock, output events, output state);
endinterface
`default_nettype wire

// >>> hdl/lslc_edge_pick.sv
`timescale 1ns/1ps
`default_nettype none
module lslc_edge_pick (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic level_i,
  input wire logic rising_i,
  output logic strobe_o
);
  logic prev;
  logic next_prev;

  always_comb begin
    next_prev = ce_i ? level_i : prev;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prev <= 1'b0;
    end else begin
      prev <= next_prev;
    end
  end

  // The sampled clock is compared against its last sample only.
  assign strobe_o = ce_i & (rising_i ? (level_i & ~prev) : (~level_i & prev));
endmodule // lslc_edge_pick
`default_nettype wire

// >>> hdl/lslc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module lslc_regs (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [lslc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o,
  lslc_reg_if.regs bus
);
  import lslc_pkg::*;
  logic [1:0] ctrl, next_ctrl;
  logic [EVT_W-1:0] status, next_status, mask, next_mask;
  logic [31:0] rdata, next_rdata;

  always_comb begin
    next_ctrl = ctrl;
    next_mask = mask;
    next_status = status;
    next_rdata = 32'h0000_0000;
    next_ctrl[CTRL_RELOCK_BIT] = 1'b0;
    if (reg_we_i && reg_addr_i == REG_CTRL) begin
      next_ctrl = reg_wdata_i[1:0];
    end
    if (reg_we_i && reg_addr_i == REG_MASK) begin
      next_mask = reg_wdata_i[EVT_W-1:0];
    end
    if (reg_re_i) begin
      case (reg_addr_i)
        REG_CTRL: next_rdata = {30'h0, 1'b0, ctrl[CTRL_TX_EN_BIT]};
        REG_STATUS: next_rdata = {28'h0, status};
        REG_MASK: next_rdata = {28'h0, mask};
        REG_STATE: next_rdata = {{(32-STATE_W){1'b0}}, bus.state};
        default: next_rdata = 32'h0000_0000;
      endcase
      if (reg_addr_i == REG_STATUS) begin
        next_status = '0;
      end
    end
    // A new event beats the clear of a read in the same cycle.
    next_status = next_status | bus.events;
    if (!ce_i) begin
      next_ctrl = ctrl;
      next_mask = mask;
      next_status = status;
      next_rdata = rdata;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RESET;
      mask <= MASK_RESET;
      status <= '0;
      rdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      mask <= next_mask;
      status <= next_status;
      rdata <= next_rdata;
    end
  end

  assign bus.tx_enable = ctrl[CTRL_TX_EN_BIT];
  assign bus.relock = ctrl[CTRL_RELOCK_BIT];
  assign reg_rdata_o = rdata;
  assign irq_o = |(status & mask);
endmodule // lslc_regs
`default_nettype wire

// >>> hdl/lslc_link_ctrl.sv
// Operation
// - Five edges of alignment request start pattern.
// - Pattern repeats while alignment request stays high.
// - Alignment request is OR of both inputs.
// - Output strobe edge follows output edge select.
// - Sleep stops lock, floats receiver data, clock and lock outputs, idles receiver.
// - Lock output goes low once locked.
// - Output enable low floats data and clock.
// - Recovered clock runs at the word rate.
// - Input capture edge follows input edge select.
// - Serial enable low floats the serial output.
// - Parallel word loads into a 10-bit register.
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module lslc_link_ctrl #(
  parameter int LOCK_FRAMES = lslc_pkg::LOCK_FRAMES_DEF,
  parameter int REF_TIMEOUT = lslc_pkg::REF_TIMEOUT_DEF
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic transmit_word_clock_i,
  input wire logic input_edge_select_i,
  input wire logic [lslc_pkg::WORD_W-1:0] parallel_data_in_i,
  input wire logic align_request_a_i,
  input wire logic align_request_b_i,
  input wire logic serial_out_enable_i,
  output logic serial_o,
  output logic serial_oe_o,
  input wire logic receiver_reference_clock_i,
  input wire logic serial_in_i,
  input wire logic output_edge_select_i,
  input wire logic sleep_n_i,
  input wire logic parallel_out_enable_i,
  output logic [lslc_pkg::WORD_W-1:0] recovered_data_out_o,
  output logic recovered_data_oe_o,
  output logic recovered_clock_o,
  output logic recovered_clock_oe_o,
  output logic recovered_word_valid_o,
  output logic pll_locked_low_o,
  output logic pll_locked_low_oe_o,
  input wire logic [lslc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o
);
  import lslc_pkg::*;

  if (LOCK_FRAMES < 1 || LOCK_FRAMES > 15) begin : g_bad_lock
    $error("LOCK_FRAMES must lie in 1 to 15");
  end
  if (REF_TIMEOUT < 4 || REF_TIMEOUT > 65535) begin : g_bad_ref
    $error("REF_TIMEOUT must lie in 4 to 65535");
  end

  lslc_reg_if rif ();

  lslc_regs u_regs (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o),
    .irq_o(irq_o),
    .bus(rif.regs)
  );

  // Transmit side: the word clock is a sampled input, not a clock domain.
  logic tx_strobe;

  lslc_edge_pick u_tx_edge (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .level_i(transmit_word_clock_i),
    .rising_i(input_edge_select_i),
    .strobe_o(tx_strobe)
  );

  logic tx_align_req;
  logic [2:0] tx_align_cnt, next_tx_align_cnt;
  logic [WORD_W-1:0] tx_in_reg, next_tx_in_reg;
  logic tx_pending, next_tx_pending;
  logic [FRAME_W-1:0] tx_sr, next_tx_sr;
  logic [CNT_W-1:0] tx_cnt, next_tx_cnt;
  logic tx_aligning, tx_load, tx_drop;

  assign tx_align_req = align_request_a_i | align_request_b_i;
  assign tx_aligning = tx_align_req && (tx_align_cnt == ALIGN_MIN_EDGES);
  assign tx_load = ce_i && (tx_cnt == FRAME_LAST);
  // A word not yet framed when the next arrives is overwritten.
  assign tx_drop = tx_strobe && tx_pending && !tx_load;

  always_comb begin
    next_tx_align_cnt = tx_align_cnt;
    next_tx_in_reg = tx_in_reg;
    next_tx_pending = tx_pending;
    next_tx_sr = tx_sr;
    next_tx_cnt = tx_cnt;
    if (ce_i) begin
      if (!tx_align_req) begin
        next_tx_align_cnt = 3'h0;
      end else if (tx_strobe && tx_align_cnt != ALIGN_MIN_EDGES) begin
        next_tx_align_cnt = tx_align_cnt + 3'h1;
      end
      if (tx_load) begin
        next_tx_cnt = '0;
        if (!rif.tx_enable) begin
          next_tx_sr = IDLE_FRAME;
        end else if (tx_aligning) begin
          next_tx_sr = ALIGN_PATTERN;
        end else if (tx_pending) begin
          next_tx_sr = {1'b1, tx_in_reg, 1'b0};
          next_tx_pending = 1'b0;
        end else begin
          next_tx_sr = IDLE_FRAME;
        end
      end else begin
        next_tx_cnt = tx_cnt + 4'h1;
        next_tx_sr = {tx_sr[FRAME_W-2:0], 1'b0};
      end
      if (tx_strobe) begin
        next_tx_in_reg = parallel_data_in_i;
        next_tx_pending = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_align_cnt <= 3'h0;
      tx_in_reg <= '0;
      tx_pending <= 1'b0;
      tx_sr <= IDLE_FRAME;
      tx_cnt <= '0;
    end else begin
      tx_align_cnt <= next_tx_align_cnt;
      tx_in_reg <= next_tx_in_reg;
      tx_pending <= next_tx_pending;
      tx_sr <= next_tx_sr;
      tx_cnt <= next_tx_cnt;
    end
  end

  assign serial_o = tx_sr[FRAME_W-1];
  assign serial_oe_o = serial_out_enable_i;

  // Receive side.
  lslc_rx_state_e rx_state, next_rx_state;
  logic [FRAME_W-1:0] rx_sr;
  logic [FRAME_W-1:0] rx_win;
  logic [CNT_W-1:0] rx_cnt, next_rx_cnt, rclk_tmr, next_rclk_tmr;
  logic [3:0] rx_good, next_rx_good;
  logic [15:0] ref_tmr, next_ref_tmr;
  logic ref_prev, ref_alive;
  logic [WORD_W-1:0] rx_data, next_rx_data;
  logic rx_valid, next_rx_valid, rclk, next_rclk;
  logic frame_end, frame_ok, rx_word_load;
  logic gained, lost;

  assign rx_win = {rx_sr[FRAME_W-2:0], serial_in_i};
  assign frame_end = ce_i && (rx_cnt == FRAME_LAST);
  // Stop bit must be low; a low start bit marks an all-zero idle frame.
  assign frame_ok = !rx_win[0] && (rx_win[FRAME_W-1] || rx_win == IDLE_FRAME);
  assign ref_alive = (ref_tmr != 16'h0000);
  assign rx_word_load = frame_end && rx_state == RX_LOCKED && frame_ok &&
    rx_win[FRAME_W-1] && rx_win != ALIGN_PATTERN;

  always_comb begin
    next_rx_state = rx_state;
    next_rx_cnt = rx_cnt;
    next_rx_good = rx_good;
    gained = 1'b0;
    lost = 1'b0;
    if (ce_i) begin
      next_rx_cnt = (rx_cnt == FRAME_LAST) ? '0 : rx_cnt + 4'h1;
      case (rx_state)
        RX_SLEEP: begin
          next_rx_state = RX_HUNT;
        end
        RX_HUNT: begin
          if (ref_alive && rx_win == ALIGN_PATTERN) begin
            next_rx_state = RX_TRAIN;
            next_rx_cnt = '0;
            next_rx_good = 4'h1;
          end
        end
        RX_TRAIN: begin
          if (frame_end) begin
            if (!frame_ok) begin
              next_rx_state = RX_HUNT;
            end else if (rx_good >= 4'(LOCK_FRAMES)) begin
              next_rx_state = RX_LOCKED;
              gained = 1'b1;
            end else begin
              next_rx_good = rx_good + 4'h1;
            end
          end
        end
        RX_LOCKED: begin
          if (frame_end && !frame_ok) begin
            next_rx_state = RX_HUNT;
            lost = 1'b1;
          end
        end
        default: begin
          next_rx_state = RX_HUNT;
        end
      endcase
      if (rx_state != RX_SLEEP && (!ref_alive || rif.relock)) begin
        next_rx_state = RX_HUNT;
        lost = (rx_state == RX_LOCKED);
      end
    end
    // Sleep waits for the clock enable so that a frozen block keeps its state.
    if (ce_i && !sleep_n_i) begin
      next_rx_state = RX_SLEEP;
      lost = (rx_state == RX_LOCKED);
    end
  end

  always_comb begin
    next_ref_tmr = ref_tmr;
    next_rx_data = rx_data;
    next_rx_valid = rx_valid;
    next_rclk_tmr = rclk_tmr;
    next_rclk = rclk;
    if (ce_i) begin
      if (receiver_reference_clock_i != ref_prev) begin
        next_ref_tmr = 16'(REF_TIMEOUT);
      end else if (ref_alive) begin
        next_ref_tmr = ref_tmr - 16'h0001;
      end
      if (rx_word_load) begin
        next_rx_data = rx_win[FRAME_W-2:1];
        next_rx_valid = 1'b1;
        next_rclk_tmr = '0;
      end else if (rclk_tmr != RCLK_DONE) begin
        next_rclk_tmr = rclk_tmr + 4'h1;
      end
      // The chosen strobe edge falls mid-word, half a frame after data change.
      next_rclk = (next_rclk_tmr != RCLK_DONE) &&
        ((next_rclk_tmr < RCLK_HALF) != output_edge_select_i);
    end
    if (next_rx_state != RX_LOCKED) begin
      next_rx_valid = 1'b0;
      next_rclk = 1'b0;
      next_rclk_tmr = RCLK_DONE;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_state <= RX_SLEEP;
      rx_sr <= '0;
      rx_cnt <= '0;
      rx_good <= 4'h0;
      ref_tmr <= 16'h0000;
      ref_prev <= 1'b0;
      rx_data <= '0;
      rx_valid <= 1'b0;
      rclk_tmr <= RCLK_DONE;
      rclk <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      rx_sr <= ce_i ? rx_win : rx_sr;
      rx_cnt <= next_rx_cnt;
      rx_good <= next_rx_good;
      ref_tmr <= next_ref_tmr;
      ref_prev <= ce_i ? receiver_reference_clock_i : ref_prev;
      rx_data <= next_rx_data;
      rx_valid <= next_rx_valid;
      rclk_tmr <= next_rclk_tmr;
      rclk <= next_rclk;
    end
  end

  assign recovered_data_out_o = rx_data;
  assign recovered_clock_o = rclk;
  assign recovered_word_valid_o = rx_valid;
  assign recovered_data_oe_o = sleep_n_i & parallel_out_enable_i;
  assign recovered_clock_oe_o = sleep_n_i & parallel_out_enable_i;
  assign pll_locked_low_o = (rx_state != RX_LOCKED);
  assign pll_locked_low_oe_o = sleep_n_i;

  always_comb begin
    rif.events = '0;
    rif.events[EVT_LOCK_GAINED] = gained;
    rif.events[EVT_LOCK_LOST] = lost;
    rif.events[EVT_ALIGN] = ce_i && tx_strobe && tx_align_req &&
      (tx_align_cnt == ALIGN_MIN_EDGES - 3'h1);
    rif.events[EVT_DROP] = tx_drop;
    rif.state = {rx_data, tx_aligning, rx_state == RX_LOCKED};
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  align_start_a: assert property ($rose(tx_aligning) |-> tx_align_req && $past(tx_strobe)) else $error("alignment began without five edges");
  align_hold_a: assert property (tx_load && tx_aligning && rif.tx_enable |=> tx_sr == ALIGN_PATTERN) else $error("alignment frame not sent");
  align_or_a: assert property (tx_align_req == (align_request_a_i || align_request_b_i)) else $error("alignment request not combined");
  out_edge_a: assert property (rx_word_load |=> recovered_clock_o == !$past(output_edge_select_i)) else $error("recovered clock phase wrong");
  sleep_float_a: assert property (!sleep_n_i |-> !recovered_data_oe_o && !recovered_clock_oe_o && !pll_locked_low_oe_o) else $error("outputs driven in sleep");
  sleep_state_a: assert property (!sleep_n_i && ce_i |=> rx_state == RX_SLEEP && !recovered_word_valid_o) else $error("receiver active in sleep");
  lock_out_a: assert property ($rose(rx_state == RX_LOCKED) |-> !pll_locked_low_o && $past(frame_end && frame_ok)) else $error("lock without good frame");
  oe_float_a: assert property (!parallel_out_enable_i |-> !recovered_data_oe_o && !recovered_clock_oe_o) else $error("outputs driven while disabled");
  word_rate_a: assert property (rx_word_load |=> !rx_word_load [*8]) else $error("words closer than one frame");
  in_reg_a: assert property (tx_strobe |=> tx_in_reg == $past(parallel_data_in_i) && tx_pending) else $error("input word not captured");
  ser_float_a: assert property (serial_oe_o == serial_out_enable_i) else $error("serial enable ignored");
  word_order_a: assert property (rx_word_load |=> recovered_data_out_o == $past(rx_win[FRAME_W-2:1]) && recovered_word_valid_o) else $error("recovered word wrong");
  unlock_a: assert property (recovered_word_valid_o || recovered_clock_o |-> rx_state == RX_LOCKED && !pll_locked_low_o) else $error("valid while unlocked");

  align_seen_c: cover property ($rose(tx_aligning));
  lock_seen_c: cover property ($rose(rx_state == RX_LOCKED));
  word_seen_c: cover property (rx_word_load ##12 rx_word_load);
  lost_seen_c: cover property (lost);
endmodule // lslc_link_ctrl
`default_nettype wire

// >>> sim/lslc_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module lslc_far_end (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic send_align_i,
  input wire logic [lslc_pkg::WORD_W-1:0] send_word_i,
  input wire logic serial_i,
  output logic serial_o,
  output logic took_o,
  output logic got_word_o,
  output logic got_align_o,
  output logic [lslc_pkg::WORD_W-1:0] got_data_o
);
  import lslc_pkg::*;
  logic [FRAME_W-1:0] tx_sh;
  logic [FRAME_W-1:0] rx_sh;
  logic [FRAME_W-1:0] win;
  logic [CNT_W-1:0] tx_cnt;
  logic [CNT_W-1:0] rx_cnt;
  logic framed;
  assign win = {rx_sh[FRAME_W-2:0], serial_i};
  assign serial_o = tx_sh[FRAME_W-1];
  // Framing is found once on the pattern and then free-runs, as a real
  // receiver would; random words must not be able to reframe it.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_sh <= IDLE_FRAME;
      rx_sh <= IDLE_FRAME;
      tx_cnt <= '0;
      rx_cnt <= '0;
      framed <= 1'b0;
      took_o <= 1'b0;
      got_word_o <= 1'b0;
      got_align_o <= 1'b0;
      got_data_o <= '0;
    end else begin
      rx_sh <= win;
      took_o <= 1'b0;
      got_word_o <= 1'b0;
      got_align_o <= 1'b0;
      tx_cnt <= (tx_cnt == FRAME_LAST) ? '0 : tx_cnt + 4'h1;
      if (tx_cnt == FRAME_LAST) begin
        tx_sh <= send_align_i ? ALIGN_PATTERN : {1'b1, send_word_i, 1'b0};
        took_o <= !send_align_i;
      end else
        tx_sh <= tx_sh << 1;
      if (framed ? (rx_cnt == FRAME_LAST) : (win == ALIGN_PATTERN)) begin
        framed <= 1'b1;
        rx_cnt <= '0;
        got_align_o <= (win == ALIGN_PATTERN);
        got_word_o <= win[FRAME_W-1] && !win[0] && win != ALIGN_PATTERN;
        got_data_o <= win[FRAME_W-2:1];
      end else
        rx_cnt <= rx_cnt + 4'h1;
    end
  end
endmodule // lslc_far_end
`default_nettype wire

// >>> sim/lslc_link_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module lslc_link_ctrl_test;
  import lslc_pkg::*;
  logic clock = 1'b0, rst = 1'b1, junk = 1'b0, ref_clk = 1'b0, rclk_q = 1'b0;
  logic word_clk = 1'b0, in_sel = 1'b1, req_a = 1'b0, req_b = 1'b0;
  logic ser_en = 1'b1, out_sel = 1'b1, sleep_n = 1'b1, par_oe = 1'b1;
  logic far_align = 1'b1, ser, ser_oe, far_ser, took, got_word, got_align;
  logic [WORD_W-1:0] par_data = '0, far_word = '0, got_data, rec_data;
  logic [WORD_W-1:0] rec_q = '0;
  logic rec_oe, rclk, rclk_oe, valid, lock_n, lock_oe, irq, tx_wire;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, rdv;
  logic reg_we = 1'b0, reg_re = 1'b0, ce = 1'b1;
  logic [31:0] seed_a = 32'h62DC, seed_b = 32'h62DC;
  logic [WORD_W-1:0] txq[$], rxq[$];
  int err_total = 0, check_count = 0, align_cnt = 0, rx_seen = 0;
  always #12.5 clock = ~clock;
  always #25 ref_clk = ~ref_clk;
  always @(posedge clock) junk <= ~junk;
  // A released serial line shows a toggling pattern, never a held value.
  assign tx_wire = ser_oe ? ser : junk;
  lslc_link_ctrl #(.REF_TIMEOUT(8)) i_lslc_link_ctrl (
    .clock_i(clock), .rst_i(rst), .ce_i(ce),
    .transmit_word_clock_i(word_clk), .input_edge_select_i(in_sel),
    .parallel_data_in_i(par_data), .align_request_a_i(req_a),
    .align_request_b_i(req_b), .serial_out_enable_i(ser_en),
    .serial_o(ser), .serial_oe_o(ser_oe),
    .receiver_reference_clock_i(ref_clk), .serial_in_i(far_ser),
    .output_edge_select_i(out_sel), .sleep_n_i(sleep_n),
    .parallel_out_enable_i(par_oe), .recovered_data_out_o(rec_data),
    .recovered_data_oe_o(rec_oe), .recovered_clock_o(rclk),
    .recovered_clock_oe_o(rclk_oe), .recovered_word_valid_o(valid),
    .pll_locked_low_o(lock_n), .pll_locked_low_oe_o(lock_oe),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we),
    .reg_re_i(reg_re), .reg_rdata_o(reg_rdata), .irq_o(irq));
  lslc_far_end i_lslc_far_end (
    .clock_i(clock), .rst_i(rst), .send_align_i(far_align),
    .send_word_i(far_word), .serial_i(tx_wire), .serial_o(far_ser),
    .took_o(took), .got_word_o(got_word), .got_align_o(got_align),
    .got_data_o(got_data));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // A word whose frame equals the alignment pattern would be taken as one.
  function automatic logic [WORD_W-1:0] pick(input logic [31:0] s);
    logic [WORD_W-1:0] w;
    w = s[WORD_W-1:0];
    return (w == ALIGN_PATTERN[FRAME_W-2:1]) ? ~w : w;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clock);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clock);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // The word clock is scaled to one word per frame of system cycles.
  task automatic tx_words(input int n, input logic sel, input logic push);
    logic [WORD_W-1:0] w;
    @(posedge clock);
    in_sel <= sel;
    word_clk <= !sel;
    repeat (n) begin
      @(posedge clock);
      seed_a = lfsr(seed_a);
      w = push ? pick(seed_a) : '0;
      par_data <= w;
      word_clk <= sel;
      if (push)
        txq.push_back(w);
      repeat (6) @(posedge clock);
      // Other data at the unselected edge shows a capture on the wrong edge.
      par_data <= ~w;
      word_clk <= !sel;
      repeat (5) @(posedge clock);
    end
  endtask
  always @(posedge clock) begin
    if (took === 1'b1) begin
      rxq.push_back(far_word);
      seed_b = lfsr(seed_b);
      far_word <= pick(seed_b);
    end
    if (got_align === 1'b1)
      align_cnt++;
    if (got_word === 1'b1 && txq.size() > 0)
      chk({22'h0, got_data}, {22'h0, txq.pop_front()});
    rclk_q <= rclk;
    rec_q <= rec_data;
    // Data seen just before the strobe must already be the word.
    if (rclk !== rclk_q && rclk === out_sel && valid === 1'b1) begin
      rx_seen++;
      if (rxq.size() > 0)
        chk({22'h0, rec_q}, {22'h0, rxq.pop_front()});
    end
  end
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    summarize();
  end
  initial begin
    int i;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd(REG_CTRL, rdv);
    chk(rdv, 32'h1);
    rd(REG_MASK, rdv);
    chk(rdv, 32'h0);
    rd(8'h10, rdv);
    chk(rdv, 32'h0);
    chk({30'h0, lock_n, irq}, 32'h2);
    wr(REG_MASK, 32'h1);
    req_b <= 1'b1;
    tx_words(4, 1'b1, 1'b0);
    req_b <= 1'b0;
    chk(align_cnt, 0);
    @(posedge clock);
    req_b <= 1'b1;
    tx_words(5, 1'b0, 1'b0);
    req_b <= 1'b0;
    req_a <= 1'b1;
    tx_words(5, 1'b0, 1'b0);
    req_a <= 1'b0;
    chk(align_cnt >= 4, 1);
    wr(REG_CTRL, 32'h3);
    @(posedge clock);
    #1 chk({31'h0, lock_n}, 32'h1);
    rd(REG_CTRL, rdv);
    chk(rdv, 32'h1);
    for (i = 0; i < 600 && lock_n !== 1'b0; i++)
      @(posedge clock);
    if (i == 600) begin
      err_total++;
      summarize();
    end
    chk(valid, 0);
    repeat (3) @(posedge clock);
    chk(irq, 1);
    rd(REG_STATUS, rdv);
    chk(rdv & 32'h7, 32'h7);
    rd(REG_STATE, rdv);
    chk(rdv[STATE_LOCKED_BIT], 1);
    chk(irq, 0);
    repeat (30) @(posedge clock);
    for (int p = 0; p < 4; p++) begin
      @(posedge clock);
      out_sel <= p[0];
      repeat (2) @(posedge clock);
      far_align <= 1'b0;
      tx_words(6, p[1], 1'b1);
      far_align <= 1'b1;
      repeat (36) @(posedge clock);
    end
    chk(txq.size(), 0);
    chk(rxq.size(), 0);
    chk(rx_seen >= 16, 1);
    ser_en <= 1'b0;
    par_oe <= 1'b0;
    @(posedge clock);
    #1 chk({28'h0, ser_oe, rec_oe, rclk_oe, lock_oe}, 32'h1);
    @(posedge clock);
    sleep_n <= 1'b0;
    par_oe <= 1'b1;
    ce <= 1'b0;
    repeat (3) @(posedge clock);
    #1 chk({31'h0, lock_n}, 32'h0);
    @(posedge clock);
    ce <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk({28'h0, rec_oe, lock_oe, lock_n, valid}, 32'h2);
    summarize();
  end
endmodule // lslc_link_ctrl_test
`default_nettype wire
